// *** hdl/pirq_consts.svh ***
// offsets, field positions and reset values of the endpoint interrupt request block
// Function
// RULE1: legacy raise: request plus assert-select, selector
// RULE2: core pulses accept for pending assert
// RULE3: accepted assert sends Assert_INTx unless disabled
// RULE4: withdraw: request, assert-select low, same selector
// RULE5: withdraw accepted, then Deassert_INTx is sent
// RULE6: legacy user drops request after accept
// RULE7: selector 00h is INTA, others unsupported
// RULE8: MSI raise: request, vector when multi-vector
// RULE9: MSI accept then one memory write
// RULE10: MSI user drops request unless more follow
// RULE11: write address and payload from capability fields
// RULE12: 64-bit write only when upper address nonzero
// RULE13: multi-vector needs nonzero enable, field is output
// RULE14: override bits: lesser of capable and enable
// RULE15: vector bits beyond enable are masked off
// RULE16: user pads vector with zeros, bounded range
// RULE17: user checks per-vector mask, core ignores it
// RULE18: MSI-X built by user on transmit path
// RULE19: MSI enable picks MSI, else legacy INTx
// RULE20: INTx disable blocks legacy messages
// RULE21: accept only one cycle, only with request
`ifndef PIRQ_CONSTS_SVH
`define PIRQ_CONSTS_SVH
`define PIRQ_OFS_CTRL       8'h00
`define PIRQ_OFS_ADDR_LO    8'h04
`define PIRQ_OFS_ADDR_HI    8'h08
`define PIRQ_OFS_DATA       8'h0c
`define PIRQ_OFS_STATUS     8'h10
`define PIRQ_CTRL_MSI_EN    0
`define PIRQ_CTRL_MSIX_EN   1
`define PIRQ_CTRL_INTX_DIS  2
`define PIRQ_CTRL_MMEN_LSB  4
`define PIRQ_STAT_INTX_ON   0
`define PIRQ_STAT_BUSY      1
`define PIRQ_STAT_BADSEL    2
`define PIRQ_STAT_MMCAP_LSB 8
`define PIRQ_STAT_CNT_LSB   16
`define PIRQ_MMCAP          3'h5
`define PIRQ_INTA_SEL       8'h00
`define PIRQ_RESP_OKAY      2'h0
`define PIRQ_RESP_SLVERR    2'h2
`define PIRQ_RST_WORD       32'h0000_0000
`endif

// *** hdl/pirq_pkg.sv ***
// types of the endpoint interrupt request block
package pirq_pkg;
	// request engine states, one-hot
	typedef enum logic [2:0]
	{
		PIRQ_ST_IDLE = 3'b001,
		PIRQ_ST_SEND = 3'b010,
		PIRQ_ST_GAP  = 3'b100
	} pirq_state_type;
	// outgoing packet kinds
	typedef enum logic [1:0]
	{
		PIRQ_K_ASSERT   = 2'h0,
		PIRQ_K_DEASSERT = 2'h1,
		PIRQ_K_MWR32    = 2'h2,
		PIRQ_K_MWR64    = 2'h3
	} pirq_kind_type;
endpackage

// *** hdl/pirq_msg_if.sv ***
// carrier for one outgoing interrupt packet between engine and output stage
`timescale 1ns/100ps
interface pirq_msg_if;
	import pirq_pkg::*;
	logic          valid; // packet offered
	logic          ready; // stage can take it
	pirq_kind_type kind;  // packet kind
	logic [63:0]   addr;  // write address
	logic [31:0]   data;  // payload or selector
	modport src (output valid, output kind, output addr, output data, input ready);
	modport snk (input valid, input kind, input addr, input data, output ready);
endinterface

// *** hdl/pirq_vecmask.sv ***
// message data composer: user vector bits merged into message data
`timescale 1ns/100ps
module pirq_vecmask
(
	input  wire logic [2:0]  mmcap_i,
	input  wire logic [2:0]  mmen_i,
	input  wire logic [7:0]  vec_i,
	input  wire logic [15:0] data_i,
	output logic [15:0]      data_o,
	output logic [7:0]       mask_o
);
	import pirq_pkg::*;
	// ==========================================================
	// override width
	logic [2:0] lesser; // bits the user may override
	assign lesser = (mmcap_i < mmen_i) ? mmcap_i : mmen_i;
	// ==========================================================
	// per-bit selection
	for (genvar b = 0; b < 8; b++)
	begin : g_bit
		// RULE14: bit open below lesser width
		assign mask_o[b] = (3'(b) < lesser) && (b < 7);
		// RULE15: closed bits keep message data
		assign data_o[b] = mask_o[b] ? vec_i[b] : data_i[b];
	end
	assign data_o[15:8] = data_i[15:8];
endmodule // pirq_vecmask

// *** hdl/pirq_txstage.sv ***
// output register stage for interrupt packets
`timescale 1ns/100ps
module pirq_txstage
(
	input  wire logic               clk_i,
	input  wire logic               rst_n_i,
	pirq_msg_if.snk                 msg,
	output logic                    tx_valid_o,
	input  wire logic               tx_ready_i,
	output pirq_pkg::pirq_kind_type tx_kind_o,
	output logic [63:0]             tx_addr_o,
	output logic [31:0]             tx_data_o
);
	import pirq_pkg::*;
	// stage free when empty or draining this cycle
	assign msg.ready = !tx_valid_o || tx_ready_i;
	// ==========================================================
	// valid flag
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			tx_valid_o <= 1'b0;
		else if (msg.valid && msg.ready)
			tx_valid_o <= 1'b1;
		else if (tx_ready_i)
			tx_valid_o <= 1'b0;
	end
	// ==========================================================
	// payload, loaded only on a take
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tx_kind_o <= PIRQ_K_ASSERT;
			tx_addr_o <= 64'h0;
			tx_data_o <= 32'h0;
		end
		else if (msg.valid && msg.ready)
		begin
			tx_kind_o <= msg.kind;
			tx_addr_o <= msg.addr;
			tx_data_o <= msg.data;
		end
	end
endmodule // pirq_txstage

// *** hdl/pirq_top.sv ***
// endpoint interrupt request engine with AXI4-Lite control registers
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`include "pirq_consts.svh"
module pirq_top
(
	input  wire logic               CORE_CLK_I,
	input  wire logic               RESETN_I,
	input  wire logic [7:0]         S_AXI_AWADDR_I,
	input  wire logic               S_AXI_AWVALID_I,
	output logic                    S_AXI_AWREADY_O,
	input  wire logic [31:0]        S_AXI_WDATA_I,
	input  wire logic [3:0]         S_AXI_WSTRB_I,
	input  wire logic               S_AXI_WVALID_I,
	output logic                    S_AXI_WREADY_O,
	output logic [1:0]              S_AXI_BRESP_O,
	output logic                    S_AXI_BVALID_O,
	input  wire logic               S_AXI_BREADY_I,
	input  wire logic [7:0]         S_AXI_ARADDR_I,
	input  wire logic               S_AXI_ARVALID_I,
	output logic                    S_AXI_ARREADY_O,
	output logic [31:0]             S_AXI_RDATA_O,
	output logic [1:0]              S_AXI_RRESP_O,
	output logic                    S_AXI_RVALID_O,
	input  wire logic               S_AXI_RREADY_I,
	input  wire logic               IRQ_REQ_I,
	input  wire logic               IRQ_ASSERT_I,
	input  wire logic [7:0]         IRQ_VECTOR_IN_I,
	output logic                    IRQ_ACCEPT_O,
	output logic                    IRQ_MSIENABLE_O,
	output logic                    IRQ_MSIXENABLE_O,
	output logic [2:0]              IRQ_MMENABLE_O,
	output logic                    TX_VALID_O,
	input  wire logic               TX_READY_I,
	output pirq_pkg::pirq_kind_type TX_KIND_O,
	output logic [63:0]             TX_ADDR_O,
	output logic [31:0]             TX_DATA_O
);
	import pirq_pkg::*;
	// ==========================================================
	// declarations
	logic           aw_held_q;  // write address captured
	logic [7:0]     aw_addr_q;  // captured write address
	logic           w_held_q;   // write data captured
	logic [31:0]    w_data_q;   // captured write data
	logic [3:0]     w_strb_q;   // captured byte enables
	logic           bvalid_q;   // write response pending
	logic [1:0]     bresp_q;    // write response code
	logic           rvalid_q;   // read data pending
	logic [1:0]     rresp_q;    // read response code
	logic [31:0]    rdata_q;    // read data word
	logic           wr_fire;    // register write this cycle
	logic [7:0]     wr_word;    // aligned write address
	logic [7:0]     rd_word;    // aligned read address
	logic           msi_en_q;   // MSI enable
	logic           msix_en_q;  // MSI-X enable
	logic           intx_dis_q; // legacy message disable
	logic [2:0]     mmen_q;     // multiple message enable
	logic [31:0]    addr_lo_q;  // message address
	logic [31:0]    addr_hi_q;  // message upper address
	logic [15:0]    mdata_q;    // message data
	logic           intx_on_q;  // legacy line asserted upstream
	logic           badsel_q;   // unsupported selector seen
	logic           badsel_d;   // next unsupported selector flag
	logic [15:0]    cnt_q;      // packets handed out
	logic [31:0]    ctrl_word;  // control register image
	logic [31:0]    stat_word;  // status register image
	pirq_state_type state_q;    // engine state
	pirq_state_type state_d;    // next engine state
	logic           take;       // request accepted this cycle
	logic           leg_ok;     // legacy selector is supported
	logic           bad_ev;     // unsupported selector taken
	logic [15:0]    vm_data;    // composed message data
	logic [7:0]     vm_mask;    // override bit mask
	logic [31:0]    ctrl_new;   // control word after byte merge
	logic [31:0]    lo_new;     // low address after byte merge
	logic [31:0]    hi_new;     // upper address after byte merge
	logic [31:0]    mdata_new;  // message data after byte merge
	pirq_msg_if     msg ();     // engine to output stage
	// merge a write word under byte enables
	function automatic logic [31:0] pirq_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				res[8*b +: 8] = new_v[8*b +: 8];
		end
		return res;
	endfunction
	// ==========================================================
	// AXI4-Lite write channels, address and data in either order
	assign S_AXI_AWREADY_O = !aw_held_q;
	assign S_AXI_WREADY_O  = !w_held_q;
	assign wr_fire         = aw_held_q && w_held_q && !bvalid_q;
	assign wr_word         = {aw_addr_q[7:2], 2'b00};
	// address holder
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			aw_held_q <= 1'b0;
			aw_addr_q <= 8'h00;
		end
		else if (wr_fire)
			aw_held_q <= 1'b0;
		else if (S_AXI_AWVALID_I && !aw_held_q)
		begin
			aw_held_q <= 1'b1;
			aw_addr_q <= S_AXI_AWADDR_I;
		end
	end
	// data holder
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			w_held_q <= 1'b0;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
		end
		else if (wr_fire)
			w_held_q <= 1'b0;
		else if (S_AXI_WVALID_I && !w_held_q)
		begin
			w_held_q <= 1'b1;
			w_data_q <= S_AXI_WDATA_I;
			w_strb_q <= S_AXI_WSTRB_I;
		end
	end
	// write response, error for unmapped words
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			bvalid_q <= 1'b0;
			bresp_q  <= `PIRQ_RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_q <= 1'b1;
			bresp_q  <= (wr_word > `PIRQ_OFS_STATUS) ? `PIRQ_RESP_SLVERR : `PIRQ_RESP_OKAY;
		end
		else if (S_AXI_BREADY_I)
			bvalid_q <= 1'b0;
	end
	assign S_AXI_BVALID_O = bvalid_q;
	assign S_AXI_BRESP_O  = bresp_q;
	// ==========================================================
	// control registers
	assign ctrl_word = {25'h0, mmen_q, 1'b0, intx_dis_q, msix_en_q, msi_en_q};
	// byte-merged images, one per writable word except status
	assign ctrl_new  = pirq_merge(ctrl_word, w_data_q, w_strb_q);
	assign lo_new    = pirq_merge(addr_lo_q, w_data_q, w_strb_q);
	assign hi_new    = pirq_merge(addr_hi_q, w_data_q, w_strb_q);
	assign mdata_new = pirq_merge({16'h0, mdata_q}, w_data_q, w_strb_q);
	// RULE19: mode and enable bits
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			msi_en_q   <= 1'b0;
			msix_en_q  <= 1'b0;
			intx_dis_q <= 1'b0;
			mmen_q     <= 3'h0;
		end
		else if (wr_fire && wr_word == `PIRQ_OFS_CTRL)
		begin
			msi_en_q   <= ctrl_new[`PIRQ_CTRL_MSI_EN];
			msix_en_q  <= ctrl_new[`PIRQ_CTRL_MSIX_EN];
			intx_dis_q <= ctrl_new[`PIRQ_CTRL_INTX_DIS];
			mmen_q     <= ctrl_new[`PIRQ_CTRL_MMEN_LSB +: 3];
		end
	end
	// RULE11: message address and data fields
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			addr_lo_q <= `PIRQ_RST_WORD;
			addr_hi_q <= `PIRQ_RST_WORD;
			mdata_q   <= 16'h0;
		end
		else if (wr_fire)
		begin
			// low address stays dword aligned
			if (wr_word == `PIRQ_OFS_ADDR_LO)
				addr_lo_q <= {lo_new[31:2], 2'b00};
			if (wr_word == `PIRQ_OFS_ADDR_HI)
				addr_hi_q <= hi_new;
			if (wr_word == `PIRQ_OFS_DATA)
				mdata_q <= mdata_new[15:0];
		end
	end
	// RULE13: enable field exposed to the user
	assign IRQ_MMENABLE_O   = mmen_q;
	assign IRQ_MSIENABLE_O  = msi_en_q;
	// RULE18: MSI-X is left to the user's transmit path
	assign IRQ_MSIXENABLE_O = msix_en_q;
	// ==========================================================
	// AXI4-Lite read channel
	assign stat_word = {cnt_q, 5'h0, `PIRQ_MMCAP, 5'h0, badsel_q,
		(state_q != PIRQ_ST_IDLE) || TX_VALID_O, intx_on_q};
	assign rd_word   = {S_AXI_ARADDR_I[7:2], 2'b00};
	assign S_AXI_ARREADY_O = !rvalid_q;
	// read data and response
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0;
			rresp_q  <= `PIRQ_RESP_OKAY;
		end
		else if (S_AXI_ARVALID_I && !rvalid_q)
		begin
			rvalid_q <= 1'b1;
			rresp_q  <= `PIRQ_RESP_OKAY;
			unique case (rd_word)
				`PIRQ_OFS_CTRL:    rdata_q <= ctrl_word;
				`PIRQ_OFS_ADDR_LO: rdata_q <= addr_lo_q;
				`PIRQ_OFS_ADDR_HI: rdata_q <= addr_hi_q;
				`PIRQ_OFS_DATA:    rdata_q <= {16'h0, mdata_q};
				`PIRQ_OFS_STATUS:  rdata_q <= stat_word;
				default:
				begin
					rdata_q <= 32'h0;
					rresp_q <= `PIRQ_RESP_SLVERR;
				end
			endcase
		end
		else if (S_AXI_RREADY_I)
			rvalid_q <= 1'b0;
	end
	assign S_AXI_RVALID_O = rvalid_q;
	assign S_AXI_RDATA_O  = rdata_q;
	assign S_AXI_RRESP_O  = rresp_q;
	// ==========================================================
	// request engine
	// RULE2 RULE21: accept only in idle with a request
	assign take         = (state_q == PIRQ_ST_IDLE) && IRQ_REQ_I;
	assign IRQ_ACCEPT_O = take;
	// RULE7: only the INTA selector is served
	assign leg_ok = (IRQ_VECTOR_IN_I == `PIRQ_INTA_SEL);
	assign bad_ev = take && !msi_en_q && !leg_ok;
	// next state
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			PIRQ_ST_IDLE:
			begin
				// RULE20: disabled or unsupported legacy goes silent
				if (take && (msi_en_q || (leg_ok && !intx_dis_q)))
					state_d = PIRQ_ST_SEND;
				else if (take)
					state_d = PIRQ_ST_GAP;
			end
			PIRQ_ST_SEND:
			begin
				if (msg.ready)
					state_d = PIRQ_ST_IDLE;
			end
			// RULE6: one quiet cycle while the user drops its request
			PIRQ_ST_GAP:
				state_d = PIRQ_ST_IDLE;
		endcase
	end
	// state register
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			state_q <= PIRQ_ST_IDLE;
		else
			state_q <= state_d;
	end
	// RULE14: user vector merged into message data
	pirq_vecmask u_vecmask
	(
		.mmcap_i (`PIRQ_MMCAP),
		.mmen_i  (mmen_q),
		.vec_i   (IRQ_VECTOR_IN_I),
		.data_i  (mdata_q),
		.data_o  (vm_data),
		.mask_o  (vm_mask)
	);
	// packet payload captured at accept
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			msg.kind <= PIRQ_K_ASSERT;
			msg.addr <= 64'h0;
			msg.data <= 32'h0;
		end
		else if (take && msi_en_q)
		begin
			// RULE9: one memory write per accepted request
			// RULE12: wide address only with nonzero upper half
			msg.kind <= (addr_hi_q != 32'h0) ? PIRQ_K_MWR64 : PIRQ_K_MWR32;
			msg.addr <= {addr_hi_q, addr_lo_q};
			msg.data <= {16'h0, vm_data};
		end
		else if (take)
		begin
			// RULE3: raise selects the assert message
			// RULE5: withdraw selects the deassert message
			msg.kind <= IRQ_ASSERT_I ? PIRQ_K_ASSERT : PIRQ_K_DEASSERT;
			msg.addr <= 64'h0;
			msg.data <= {24'h0, IRQ_VECTOR_IN_I};
		end
	end
	assign msg.valid = (state_q == PIRQ_ST_SEND);
	// legacy line image, follows sent messages only
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			intx_on_q <= 1'b0;
		else if (take && !msi_en_q && leg_ok && !intx_dis_q)
			intx_on_q <= IRQ_ASSERT_I;
	end
	// unsupported selector flag, set beats write-one clear
	always_comb
	begin
		badsel_d = badsel_q;
		if (wr_fire && wr_word == `PIRQ_OFS_STATUS && w_strb_q[0] && w_data_q[`PIRQ_STAT_BADSEL])
			badsel_d = 1'b0;
		if (bad_ev)
			badsel_d = 1'b1;
	end
	// flag register
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			badsel_q <= 1'b0;
		else
			badsel_q <= badsel_d;
	end
	// handed-out packet counter
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			cnt_q <= 16'h0;
		else if (msg.valid && msg.ready)
			cnt_q <= cnt_q + 16'h1;
	end
	// output register stage
	pirq_txstage u_txstage
	(
		.clk_i      (CORE_CLK_I),
		.rst_n_i    (RESETN_I),
		.msg        (msg.snk),
		.tx_valid_o (TX_VALID_O),
		.tx_ready_i (TX_READY_I),
		.tx_kind_o  (TX_KIND_O),
		.tx_addr_o  (TX_ADDR_O),
		.tx_data_o  (TX_DATA_O)
	);
	// ==========================================================
	// checks
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RESETN_I);
	logic [7:0] chk_en_mask; // vector bits allowed by enable
	assign chk_en_mask = 8'((9'h1 << mmen_q) - 9'h1);
	sequence s_msi_take;
		IRQ_ACCEPT_O && msi_en_q;
	endsequence
	sequence s_leg_take(bit as);
		IRQ_ACCEPT_O && !msi_en_q && leg_ok && !intx_dis_q && (IRQ_ASSERT_I == as);
	endsequence
	chk_accept_req : assert property (IRQ_ACCEPT_O |-> IRQ_REQ_I) // RULE21
		else $error("accept without request");
	chk_accept_one : assert property (IRQ_ACCEPT_O |=> !IRQ_ACCEPT_O) // RULE21
		else $error("accept longer than one cycle");
	chk_raise_taken : assert property ((IRQ_REQ_I && IRQ_ASSERT_I && !msi_en_q
		&& state_q == PIRQ_ST_IDLE) |-> IRQ_ACCEPT_O ##1 state_q != PIRQ_ST_IDLE) // RULE2
		else $error("pending raise not accepted");
	chk_assert_msg : assert property (s_leg_take(1'b1) |=> msg.valid
		&& msg.kind == PIRQ_K_ASSERT) // RULE3
		else $error("assert message missing");
	chk_deassert_msg : assert property (s_leg_take(1'b0) |=> msg.valid
		&& msg.kind == PIRQ_K_DEASSERT) // RULE5
		else $error("deassert message missing");
	chk_intx_block : assert property ((IRQ_ACCEPT_O && !msi_en_q && intx_dis_q)
		|=> !msg.valid ##1 !msg.valid) // RULE20
		else $error("legacy message while disabled");
	chk_bad_selector : assert property ((IRQ_ACCEPT_O && !msi_en_q && !leg_ok)
		|=> !msg.valid && badsel_q) // RULE7
		else $error("unsupported selector sent");
	chk_msi_write : assert property (s_msi_take |=> msg.valid
		&& (msg.kind == PIRQ_K_MWR32 || msg.kind == PIRQ_K_MWR64)) // RULE9
		else $error("memory write missing");
	chk_mode_pick : assert property ((msg.valid && msg.kind[1]) |-> $past(msi_en_q, 1)
		|| $past(state_q == PIRQ_ST_SEND)) // RULE19
		else $error("memory write outside MSI mode");
	chk_addr_width : assert property (s_msi_take |=> (msg.kind == PIRQ_K_MWR64)
		== (msg.addr[63:32] != 32'h0)) // RULE12
		else $error("address width mismatch");
	chk_addr_src : assert property (s_msi_take |=> msg.addr
		== {$past(addr_hi_q), $past(addr_lo_q)}) // RULE11
		else $error("write address not from capability");
	chk_single_vec : assert property ((s_msi_take and mmen_q == 3'h0)
		|=> msg.data == {16'h0, $past(mdata_q)}) // RULE13
		else $error("vector leaked with multi-vector off");
	chk_lesser_bits : assert property (s_msi_take |=> ((msg.data[15:0]
		^ $past(mdata_q)) & ~{8'h0, $past(vm_mask)}) == 16'h0) // RULE14
		else $error("override beyond lesser width");
	chk_vec_masked : assert property (s_msi_take |=> ((msg.data[7:0]
		^ $past(mdata_q[7:0])) & ~$past(chk_en_mask)) == 8'h0) // RULE15
		else $error("disabled vector bit reached data");
endmodule // pirq_top

// *** sim/pirq_user_model.sv ***
// user application model that raises and withdraws interrupt requests
`timescale 1ns/100ps
module pirq_user_model
(
	input  wire logic  clk_i,
	input  wire logic  accept_i,
	output logic       req_o,
	output logic       assert_o,
	output logic [7:0] vector_o,
	output logic       hung_o
);
	// ==========================================================
	// idle levels at time zero
	initial
	begin
		req_o = 1'b0;
		assert_o = 1'b0;
		vector_o = 8'h00;
		hung_o = 1'b0;
	end

	// ==========================================================
	// one request, waiting a lag first, holding until accepted
	task automatic request(input logic raise, input logic [7:0] vec, input int lag);
		int n;
		repeat (lag) @(posedge clk_i);
		req_o <= 1'b1;
		assert_o <= raise;
		vector_o <= vec;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (accept_i !== 1'b1 && n < 64);
		// no accept within bound: flag a hang
		if (accept_i !== 1'b1)
			hung_o <= 1'b1;
		// request dropped the cycle after accept
		req_o <= 1'b0;
		assert_o <= ~raise;
		vector_o <= ~vec;
	endtask
endmodule // pirq_user_model

// *** sim/pirq_top_tb_top.sv ***
// self-checking bench for the interrupt request engine
`timescale 1ns/100ps
`include "pirq_consts.svh"
module pirq_top_tb_top;
	import pirq_pkg::*;
	logic          clk, rst_n, awvalid, wvalid, bready, arvalid, rready, tx_ready;
	logic [7:0]    awaddr, araddr;
	logic [31:0]   wdata;
	logic [3:0]    wstrb;
	wire           awready, wready, bvalid, arready, rvalid;
	wire [1:0]     bresp, rresp;
	wire [31:0]    rdata;
	wire           irq_req, irq_assert, irq_accept, msi_en, msix_en, hung;
	wire [7:0]     irq_vec;
	wire [2:0]     mmen;
	wire           tx_valid;
	pirq_kind_type tx_kind, last_kind;
	wire [63:0]    tx_addr;
	wire [31:0]    tx_data;
	logic [63:0]   last_addr;
	logic [31:0]   last_data;
	logic [15:0]   msk;
	int            num_errors = 0, total_checks = 0, pkt_cnt = 0, acc_cnt = 0, k;

	// ==========================================================
	// clock and instances
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	pirq_top i_pirq_top (.CORE_CLK_I(clk), .RESETN_I(rst_n), .S_AXI_AWADDR_I(awaddr),
		.S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
		.S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
		.S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
		.S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
		.S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
		.S_AXI_RREADY_I(rready), .IRQ_REQ_I(irq_req), .IRQ_ASSERT_I(irq_assert),
		.IRQ_VECTOR_IN_I(irq_vec), .IRQ_ACCEPT_O(irq_accept), .IRQ_MSIENABLE_O(msi_en),
		.IRQ_MSIXENABLE_O(msix_en), .IRQ_MMENABLE_O(mmen), .TX_VALID_O(tx_valid),
		.TX_READY_I(tx_ready), .TX_KIND_O(tx_kind), .TX_ADDR_O(tx_addr), .TX_DATA_O(tx_data));
	pirq_user_model i_pirq_user_model (.clk_i(clk), .accept_i(irq_accept), .req_o(irq_req),
		.assert_o(irq_assert), .vector_o(irq_vec), .hung_o(hung));

	// ==========================================================
	// packet and accept monitor, counts handshakes
	always @(posedge clk)
	begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1)
		begin
			pkt_cnt <= pkt_cnt + 1;
			last_kind <= tx_kind;
			last_addr <= tx_addr;
			last_data <= tx_data;
		end
		if (irq_accept === 1'b1)
			acc_cnt <= acc_cnt + 1;
	end

	// ==========================================================
	// compare, verdict and bounded waits
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic guard(inout int n);
		n++;
		if (n > 60)
		begin
			num_errors++;
			finish_test();
		end
	endtask
	task automatic wait_pkt(input int cnt);
		int n;
		n = 0;
		while (pkt_cnt != cnt)
		begin
			@(posedge clk);
			guard(n);
		end
	endtask

	// ==========================================================
	// AXI4-Lite master tasks, response and data checked inside
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic fin;
		n = 0;
		fin = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!fin)
		begin
			@(posedge clk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
			if (bvalid === 1'b1)
			begin
				check(bresp, er);
				bready <= 1'b0;
				fin = 1'b1;
			end
			guard(n);
		end
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		logic fin;
		n = 0;
		fin = 1'b0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!fin)
		begin
			@(posedge clk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
			if (rvalid === 1'b1)
			begin
				check(rdata, ed);
				check(rresp, er);
				rready <= 1'b0;
				fin = 1'b1;
			end
			guard(n);
		end
	endtask

	// ==========================================================
	// hang cut-off for the whole run
	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		finish_test();
	end

	// ==========================================================
	// main sequence
	initial
	begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hf;
		tx_ready = 1'b1;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		axi_rd(`PIRQ_OFS_CTRL, 32'h0000_0000, `PIRQ_RESP_OKAY);
		axi_rd(`PIRQ_OFS_STATUS, 32'h0000_0500, `PIRQ_RESP_OKAY);
		axi_rd(8'h14, 32'h0000_0000, `PIRQ_RESP_SLVERR);
		axi_wr(8'h14, 32'hffff_ffff, `PIRQ_RESP_SLVERR);
		// legacy raise, unsupported selector, withdraw
		i_pirq_user_model.request(1'b1, `PIRQ_INTA_SEL, 0);
		wait_pkt(1);
		check(last_kind, PIRQ_K_ASSERT);
		check(last_data, 32'h0000_0000);
		axi_rd(`PIRQ_OFS_STATUS, 32'h0001_0501, `PIRQ_RESP_OKAY);
		i_pirq_user_model.request(1'b1, 8'h01, 2);
		repeat (8) @(posedge clk);
		check(pkt_cnt, 1);
		axi_rd(`PIRQ_OFS_STATUS, 32'h0001_0505, `PIRQ_RESP_OKAY);
		axi_wr(`PIRQ_OFS_STATUS, 32'h0000_0004, `PIRQ_RESP_OKAY);
		axi_rd(`PIRQ_OFS_STATUS, 32'h0001_0501, `PIRQ_RESP_OKAY);
		i_pirq_user_model.request(1'b0, `PIRQ_INTA_SEL, 0);
		wait_pkt(2);
		check(last_kind, PIRQ_K_DEASSERT);
		// legacy blocked while disabled
		axi_wr(`PIRQ_OFS_CTRL, 32'h0000_0004, `PIRQ_RESP_OKAY);
		i_pirq_user_model.request(1'b1, `PIRQ_INTA_SEL, 0);
		repeat (8) @(posedge clk);
		check(pkt_cnt, 2);
		// message signalled, stalled downstream
		axi_wr(`PIRQ_OFS_ADDR_LO, 32'h1234_5677, `PIRQ_RESP_OKAY);
		axi_rd(`PIRQ_OFS_ADDR_LO, 32'h1234_5674, `PIRQ_RESP_OKAY);
		axi_wr(`PIRQ_OFS_DATA, 32'h0000_ab40, `PIRQ_RESP_OKAY);
		wstrb <= 4'h2;
		axi_wr(`PIRQ_OFS_ADDR_HI, 32'hffff_ff5a, `PIRQ_RESP_OKAY);
		wstrb <= 4'hf;
		axi_rd(`PIRQ_OFS_ADDR_HI, 32'h0000_ff00, `PIRQ_RESP_OKAY);
		axi_wr(`PIRQ_OFS_ADDR_HI, 32'h0000_0000, `PIRQ_RESP_OKAY);
		axi_wr(`PIRQ_OFS_CTRL, 32'h0000_0051, `PIRQ_RESP_OKAY);
		check(msi_en, 1'b1);
		check(mmen, 3'h5);
		tx_ready <= 1'b0;
		i_pirq_user_model.request(1'b1, 8'h1f, 3);
		repeat (6) @(posedge clk);
		check(pkt_cnt, 2);
		check(tx_valid, 1'b1);
		tx_ready <= 1'b1;
		wait_pkt(3);
		check(last_kind, PIRQ_K_MWR32);
		check(last_addr, 64'h0000_0000_1234_5674);
		check(last_data, 32'h0000_ab5f);
		// every enable code, oversized vector, upper address follows code
		for (int m = 0; m < 8; m++)
		begin
			axi_wr(`PIRQ_OFS_ADDR_HI, m, `PIRQ_RESP_OKAY);
			axi_wr(`PIRQ_OFS_CTRL, {25'h0, m[2:0], 4'h1}, `PIRQ_RESP_OKAY);
			i_pirq_user_model.request(1'b1, 8'hff, 0);
			wait_pkt(4 + m);
			k = (m < 5) ? m : 5;
			msk = (16'h0001 << k) - 16'h0001;
			check(last_kind, (m == 0) ? PIRQ_K_MWR32 : PIRQ_K_MWR64);
			check(last_addr, {m[31:0], 32'h1234_5674});
			check(last_data, {16'h0, (16'hab40 & ~msk) | (16'h00ff & msk)});
		end
		axi_wr(`PIRQ_OFS_CTRL, 32'h0000_0002, `PIRQ_RESP_OKAY);
		check({msix_en, msi_en}, 2'b10);
		check(acc_cnt, 13);
		check(hung, 1'b0);
		finish_test();
	end
endmodule // pirq_top_tb_top
